// [pkg/sysctrl_pkg.sv]
// shared constants and types for the system control coprocessor access block
`default_nettype none
package sysctrl_pkg;
    // instruction field positions
    localparam int COND_HI      = 31;
    localparam int COND_LO      = 28;
    localparam int PAT_HI       = 27;
    localparam int PAT_LO       = 24;
    localparam int OP1_HI       = 23;
    localparam int OP1_LO       = 21;
    localparam int DIR_BIT      = 20;
    localparam int PRI_HI       = 19;
    localparam int PRI_LO       = 16;
    localparam int CORE_HI      = 15;
    localparam int CORE_LO      = 12;
    localparam int CPNUM_HI     = 11;
    localparam int CPNUM_LO     = 8;
    localparam int OP2_HI       = 7;
    localparam int OP2_LO       = 5;
    localparam int MARK_BIT     = 4;
    localparam int SEC_HI       = 3;
    localparam int SEC_LO       = 0;
    localparam logic [3:0] XFER_PATTERN   = 4'hE;
    localparam logic [3:0] SYSCTRL_CP_NUM = 4'hF;
    localparam logic [3:0] ID_REG_SEL     = 4'h0;
    localparam logic [2:0] OP2_CACHE      = 3'h1;
    localparam logic [2:0] OP2_TCM        = 3'h2;
    localparam int ALT_VEC_BIT  = 13;
    // identification word fields
    localparam logic [7:0]  IMPLEMENTOR_DEF = 8'h5A; // arbitrary value
    localparam logic [3:0]  ID_RSVD_VAL     = 4'h0;
    localparam logic [3:0]  ISA_REV_DEF     = 4'h5;
    localparam logic [11:0] PART_CODE_DEF   = 12'h123; // arbitrary value
    localparam logic [3:0]  HW_VER_DEF      = 4'h0;
    // cache type word fields
    localparam logic [3:0] CACHE_KIND_DEF = 4'h7;
    localparam logic [3:0] CAP_NONE       = 4'h0;
    localparam logic [3:0] CAP_4K         = 4'h3;
    localparam logic [3:0] CAP_1M         = 4'hB;
    localparam logic [2:0] WAYS_DIRECT    = 3'h0;
    localparam logic [2:0] WAYS_TWO       = 3'h1;
    localparam logic [2:0] WAYS_FOUR      = 3'h2;
    localparam logic [1:0] LINE_8WORDS    = 2'h2;
    localparam logic [31:0] DATA_RESET    = 32'h0000_0000;

    typedef enum logic [1:0] {
        KIND_NONE,
        KIND_XFER,
        KIND_OTHER
    } instr_kind_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] word;
        logic        privileged;
        logic        is_xfer;
    } coproc_req_t;

    typedef struct packed {
        logic        done;
        logic        trap;
        logic        rd_valid;
        logic [31:0] rd_data;
    } coproc_rsp_t;
endpackage
`default_nettype wire

// [core/sysctrl_coproc_id_access.sv]
// system control coprocessor access decode, privilege trap and id registers
// Behaviour
// - reset clears all state bits except bit 13
// - during reset alt vector bit follows pin
// - unprivileged transfers to coprocessor trap
// - data-op, load, store to coprocessor trap
// - transfer word layout fixed, coprocessor 1111
// - primary select picks register, secondary refines
// - unmapped accesses harmless, give unknown result (here they read zero)
// - register 0, op2 not 1/2: id
// - id word field layout
// - register 0, op2 1: cache geometry
// - data cache capacity code 0..0b1011
// - associativity codes direct, two, four
// - present data cache reports four-way
// - absent bit zero when data cache exists
// - line length field reads 0b10
`default_nettype none
module sysctrl_coproc_id_access
    import sysctrl_pkg::*;
#(
    parameter logic        DCACHE_PRESENT = 1'b1,
    parameter logic [3:0]  DCACHE_CAP     = 4'h6,
    parameter logic        ICACHE_PRESENT = 1'b1,
    parameter logic [3:0]  ICACHE_CAP     = 4'h6,
    parameter logic [3:0]  HW_VERSION     = HW_VER_DEF,
    parameter logic [7:0]  IMPLEMENTOR    = IMPLEMENTOR_DEF,
    parameter logic [11:0] PART_CODE      = PART_CODE_DEF
) (
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   resetn,
    // strap
    input  wire logic                   vector_init_pin,
    // core coprocessor request
    input  wire sysctrl_pkg::coproc_req_t req,
    // answer to core
    output sysctrl_pkg::coproc_rsp_t    rsp,
    // steering of vector base
    output logic                        alt_vector_select
);
    import sysctrl_pkg::*;

    logic        vec_pin_q1;
    logic        vec_pin_q2;
    logic        vec_pin_q3;
    logic        alt_vec_q;
    coproc_rsp_t rsp_q;
    coproc_rsp_t rsp_d;
    logic        targets_us;
    logic        is_read;
    logic [3:0]  pri_sel;
    logic [2:0]  op2_sel;
    logic [31:0] id_word;
    logic [31:0] geom_word;
    logic        priv_read;
    logic [3:0]  ans_pri_q;
    logic [2:0]  ans_op2_q;
    logic        geom_ans;
    logic        id_ans;

    // capacity code check, shared by both caches
    function automatic logic [3:0] legal_cap(input logic present, input logic [3:0] code);
        if (!present) begin
            legal_cap = CAP_NONE;
        end else if (code < CAP_4K || code > CAP_1M) begin
            legal_cap = CAP_4K;
        end else begin
            legal_cap = code;
        end
    endfunction

    // field extraction
    assign targets_us = req.word[CPNUM_HI:CPNUM_LO] == SYSCTRL_CP_NUM;
    assign is_read    = req.word[DIR_BIT];
    assign pri_sel    = req.word[PRI_HI:PRI_LO];
    assign op2_sel    = req.word[OP2_HI:OP2_LO];
    assign priv_read  = req.valid && targets_us && req.is_xfer && req.privileged && is_read;

    // read-only words
    assign id_word = {IMPLEMENTOR, ID_RSVD_VAL, ISA_REV_DEF, PART_CODE, HW_VERSION};
    assign geom_word = {3'h0, CACHE_KIND_DEF, 1'b1, 2'h0,
                        legal_cap(DCACHE_PRESENT, DCACHE_CAP),
                        DCACHE_PRESENT ? WAYS_FOUR : WAYS_DIRECT,
                        ~DCACHE_PRESENT,
                        LINE_8WORDS,
                        2'h0,
                        legal_cap(ICACHE_PRESENT, ICACHE_CAP),
                        ICACHE_PRESENT ? WAYS_FOUR : WAYS_DIRECT,
                        ~ICACHE_PRESENT,
                        LINE_8WORDS};

    // decode and trap
    always_comb begin
        rsp_d          = '0;
        rsp_d.rd_data  = DATA_RESET;
        if (req.valid && targets_us) begin
            rsp_d.done = 1'b1;
            if (!req.is_xfer) begin
                rsp_d.trap = 1'b1;
            end else if (!req.privileged) begin
                rsp_d.trap = 1'b1;
            end else if (is_read) begin
                rsp_d.rd_valid = 1'b1;
                if (pri_sel == ID_REG_SEL && op2_sel == OP2_CACHE) begin
                    rsp_d.rd_data = geom_word;
                end else if (pri_sel == ID_REG_SEL && op2_sel != OP2_TCM) begin
                    rsp_d.rd_data = id_word;
                end else begin
                    rsp_d.rd_data = DATA_RESET;
                end
            end
        end
    end

    // registered answer
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    // strap synchroniser
    always_ff @(posedge ref_clk) begin
        vec_pin_q1 <= vector_init_pin;
        vec_pin_q2 <= vec_pin_q1;
        vec_pin_q3 <= vec_pin_q2;
    end

    // alt vector bit follows pin while held in reset
    always_ff @(posedge ref_clk) begin
        if (!resetn && vec_pin_q2 == vec_pin_q3) begin
            alt_vec_q <= vec_pin_q2;
        end
    end

    assign rsp               = rsp_q;
    assign alt_vector_select = alt_vec_q;

    // selector of the answered request, for the checks below
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ans_pri_q <= 4'h0;
            ans_op2_q <= 3'h0;
        end else begin
            ans_pri_q <= pri_sel;
            ans_op2_q <= op2_sel;
        end
    end

    assign geom_ans = rsp.rd_valid && ans_pri_q == ID_REG_SEL && ans_op2_q == OP2_CACHE;
    assign id_ans   = rsp.rd_valid && ans_pri_q == ID_REG_SEL && ans_op2_q != OP2_CACHE
                      && ans_op2_q != OP2_TCM;

    a_trap_other_ops : assert property (@(posedge ref_clk) disable iff (!resetn)
        req.valid && targets_us && !req.is_xfer |=> rsp.trap && rsp.done)
        else $error("data-op/load/store not trapped");

    a_trap_unpriv : assert property (@(posedge ref_clk) disable iff (!resetn)
        req.valid && targets_us && !req.privileged |=> rsp.trap && !rsp.rd_valid)
        else $error("unprivileged access not trapped");

    a_id_read : assert property (@(posedge ref_clk) disable iff (!resetn)
        req.valid && targets_us && req.is_xfer && req.privileged && is_read
        && pri_sel == 4'h0 && op2_sel != 3'h1 && op2_sel != 3'h2
        |=> rsp.rd_valid && rsp.rd_data == id_word)
        else $error("id word not returned");

    a_geom_read : assert property (@(posedge ref_clk) disable iff (!resetn)
        req.valid && targets_us && req.is_xfer && req.privileged && is_read
        && pri_sel == 4'h0 && op2_sel == 3'h1
        |=> rsp.rd_data == geom_word && !rsp.trap)
        else $error("cache geometry not returned");

    a_line_words : assert property (@(posedge ref_clk) disable iff (!resetn)
        rsp.rd_valid && $past(op2_sel) == 3'h1 && $past(pri_sel) == 4'h0
        |-> rsp.rd_data[13:12] == 2'h2 && rsp.rd_data[23:22] == 2'h0)
        else $error("line length or reserved field wrong");

    a_dcache_ways : assert property (@(posedge ref_clk) disable iff (!resetn)
        geom_ans |-> rsp.rd_data[17:15] == (DCACHE_PRESENT ? 3'h2 : 3'h0)
        && rsp.rd_data[14] == !DCACHE_PRESENT)
        else $error("associativity or absent bit wrong");

    a_reset_clear : assert property (@(posedge ref_clk)
        !resetn |=> !rsp.done && !rsp.trap && rsp.rd_data == 32'h0)
        else $error("answer not cleared by reset");

    a_strap_load : assert property (@(posedge ref_clk)
        !resetn && $past(!resetn) && vec_pin_q2 == vec_pin_q3
        |=> alt_vector_select == $past(vec_pin_q2))
        else $error("alt vector bit not loaded from pin");

    a_alt_hold : assert property (@(posedge ref_clk)
        resetn && $past(resetn)
        |-> $stable(alt_vector_select))
        else $error("alt vector bit moved outside reset");

    a_rst_no_data : assert property (@(posedge ref_clk)
        !resetn
        |=> !rsp.rd_valid && !rsp.trap)
        else $error("read or trap shown after reset");

    a_foreign_cp : assert property (@(posedge ref_clk) disable iff (!resetn)
        req.valid && !targets_us
        |=> !rsp.done && !rsp.trap)
        else $error("other coprocessor answered");

    a_answer_pulse : assert property (@(posedge ref_clk) disable iff (!resetn)
        req.valid && targets_us
        |=> rsp.done)
        else $error("request not answered next cycle");

    a_back_to_back : assert property (@(posedge ref_clk) disable iff (!resetn)
        req.valid && targets_us ##1 req.valid && targets_us
        |=> rsp.done)
        else $error("second of two requests not answered");

    a_idle_quiet : assert property (@(posedge ref_clk) disable iff (!resetn)
        !req.valid
        |=> rsp == '0)
        else $error("answer without request");

    a_rdv_done : assert property (@(posedge ref_clk) disable iff (!resetn)
        rsp.rd_valid
        |-> rsp.done && !rsp.trap)
        else $error("read data without done");

    a_no_trap_read : assert property (@(posedge ref_clk) disable iff (!resetn)
        priv_read
        |=> !rsp.trap && rsp.rd_valid)
        else $error("privileged read trapped");

    a_other_reg : assert property (@(posedge ref_clk) disable iff (!resetn)
        priv_read && pri_sel != ID_REG_SEL
        |=> rsp.rd_valid && rsp.rd_data == 32'h0)
        else $error("other register read not zero");

    a_write_quiet : assert property (@(posedge ref_clk) disable iff (!resetn)
        req.valid && targets_us && req.is_xfer && req.privileged && !is_read
        |=> rsp.done && !rsp.trap && !rsp.rd_valid && rsp.rd_data == 32'h0)
        else $error("write gave data or trap");

    a_tcm_read : assert property (@(posedge ref_clk) disable iff (!resetn)
        priv_read && pri_sel == ID_REG_SEL && op2_sel == OP2_TCM
        |=> rsp.rd_valid && rsp.rd_data == 32'h0)
        else $error("memory size slot not zero");

    a_data_zero : assert property (@(posedge ref_clk) disable iff (!resetn)
        !rsp.rd_valid
        |-> rsp.rd_data == 32'h0)
        else $error("data shown without read");

    a_trap_excl : assert property (@(posedge ref_clk) disable iff (!resetn)
        rsp.trap
        |-> rsp.done && !rsp.rd_valid)
        else $error("trap with read data");

    a_unpriv_nodata : assert property (@(posedge ref_clk) disable iff (!resetn)
        req.valid && targets_us && !req.privileged
        |=> rsp.rd_data == 32'h0)
        else $error("unprivileged read leaked data");

    a_trap_prio : assert property (@(posedge ref_clk) disable iff (!resetn)
        req.valid && targets_us && !req.is_xfer && !req.privileged
        |=> rsp.trap && !rsp.rd_valid)
        else $error("unprivileged data-op not trapped");

    a_id_answer : assert property (@(posedge ref_clk) disable iff (!resetn)
        priv_read && pri_sel == ID_REG_SEL && op2_sel != OP2_CACHE && op2_sel != OP2_TCM
        |=> rsp.rd_valid)
        else $error("id read gave no data");

    a_id_vendor : assert property (@(posedge ref_clk) disable iff (!resetn)
        id_ans
        |-> rsp.rd_data[31:24] == IMPLEMENTOR && rsp.rd_data[23:20] == ID_RSVD_VAL)
        else $error("id implementor or reserved field wrong");

    a_id_rev : assert property (@(posedge ref_clk) disable iff (!resetn)
        id_ans
        |-> rsp.rd_data[19:16] == ISA_REV_DEF && rsp.rd_data[15:4] == PART_CODE)
        else $error("id revision or part field wrong");

    a_id_ver : assert property (@(posedge ref_clk) disable iff (!resetn)
        id_ans
        |-> rsp.rd_data[3:0] == HW_VERSION)
        else $error("id version field wrong");

    a_dcap_legal : assert property (@(posedge ref_clk) disable iff (!resetn)
        geom_ans
        |-> rsp.rd_data[21:18] == CAP_NONE
        || (rsp.rd_data[21:18] >= CAP_4K && rsp.rd_data[21:18] <= CAP_1M))
        else $error("data cache capacity code illegal");

    a_dcap_cfg : assert property (@(posedge ref_clk) disable iff (!resetn)
        geom_ans
        |-> (rsp.rd_data[21:18] == CAP_NONE) == !DCACHE_PRESENT)
        else $error("capacity code disagrees with presence");

    a_dways_code : assert property (@(posedge ref_clk) disable iff (!resetn)
        geom_ans
        |-> rsp.rd_data[17:15] <= WAYS_FOUR)
        else $error("associativity code illegal");

    a_rsvd_zero : assert property (@(posedge ref_clk) disable iff (!resetn)
        geom_ans
        |-> rsp.rd_data[31:29] == 3'h0 && rsp.rd_data[11:10] == 2'h0)
        else $error("reserved geometry bits not zero");

    a_kind_field : assert property (@(posedge ref_clk) disable iff (!resetn)
        geom_ans
        |-> rsp.rd_data[28:25] == CACHE_KIND_DEF && rsp.rd_data[24])
        else $error("cache kind or split bit wrong");
endmodule
`default_nettype wire

// [bench/core_model.sv]
// core pipeline model issuing coprocessor instructions
`default_nettype none
module core_model
    import sysctrl_pkg::*;
(
    // clock
    input  wire logic                ref_clk,
    // request to coprocessor
    output sysctrl_pkg::coproc_req_t req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req = '0;
    // transfer word, unused op fields and reserved bits zero
    function automatic logic [31:0] instr(input logic d, input logic [3:0] p,
                                          input logic [2:0] o2, input logic [3:0] cp);
        return {4'hE, 4'hE, 3'h0, d, p, 4'h1, cp, o2, 1'b1, 4'h0};
    endfunction
    // one cycle request from a falling edge, bus inverted when released
    task automatic send(input logic [31:0] w, input logic pv, input logic xf);
        req <= '{valid: 1'b1, word: w, privileged: pv, is_xfer: xf};
        @(negedge ref_clk);
        req <= '{valid: 1'b0, word: ~w, privileged: ~pv, is_xfer: ~xf};
    endtask
endmodule
`default_nettype wire

// [bench/sysctrl_coproc_id_access_tb.sv]
// self-checking bench for the coprocessor access block
`default_nettype none
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin \
    $display("MISMATCH %s exp %h got %h", nm, ex, gt); err_total++; end end
module sysctrl_coproc_id_access_tb;
    import sysctrl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0]  DC_CAP = 4'h5;
    localparam logic [3:0]  IC_CAP = 4'h4;
    localparam logic [31:0] ID_EXP = {IMPLEMENTOR_DEF, 4'h0, 4'h5, PART_CODE_DEF, HW_VER_DEF};
    localparam logic [31:0] CT_EXP = {3'h0, 4'h7, 1'b1, 2'h0, DC_CAP, 3'h2, 1'b0, 2'h2,
                                      2'h0, IC_CAP, 3'h2, 1'b0, 2'h2};
    logic        ref_clk;
    logic        resetn;
    logic        vector_init_pin;
    coproc_req_t req;
    coproc_rsp_t rsp;
    logic        alt_vector_select;
    int          err_total;
    int          n_tests;
    sysctrl_coproc_id_access #(
        .DCACHE_CAP (DC_CAP),
        .ICACHE_CAP (IC_CAP)
    ) u_dut (
        .ref_clk           (ref_clk),
        .resetn            (resetn),
        .vector_init_pin   (vector_init_pin),
        .req               (req),
        .rsp               (rsp),
        .alt_vector_select (alt_vector_select)
    );
    core_model u_core (
        .ref_clk (ref_clk),
        .req     (req)
    );
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    function automatic logic [34:0] rs(input logic [1:0] f, input logic [31:0] d);
        return {1'b1, f, d};
    endfunction
    task automatic tally_and_finish;
        if (err_total == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic t_reset(input logic pin);
        vector_init_pin = pin;
        resetn = 1'b0;
        repeat (5) @(negedge ref_clk);
        `CHK("rsp_rst", 35'h0, rsp)
        `CHK("alt_rst", pin, alt_vector_select)
        resetn = 1'b1;
        @(negedge ref_clk);
        vector_init_pin = ~pin;
        repeat (4) @(negedge ref_clk);
        `CHK("alt_hold", pin, alt_vector_select)
    endtask
    task automatic xact(input string nm, input logic d, input logic [3:0] p, input logic [2:0] o2,
                        input logic [3:0] cp, input logic pv, input logic xf,
                        input logic [34:0] ex);
        u_core.send(u_core.instr(d, p, o2, cp), pv, xf);
        `CHK(nm, ex, rsp)
        @(negedge ref_clk);
        `CHK("rsp_idle", 35'h0, rsp)
    endtask
    task automatic t_reg0;
        for (int k = 0; k < 8; k++) begin
            if (k != 1) begin
                xact("reg0", 1'b1, 4'h0, 3'(k), 4'hF, 1'b1, 1'b1,
                     rs(2'h1, k == 2 ? 32'h0 : ID_EXP));
            end
        end
    endtask
    task automatic t_cache;
        u_core.send(u_core.instr(1'b1, 4'h0, 3'h1, 4'hF), 1'b1, 1'b1);
        `CHK("ct_word", rs(2'h1, CT_EXP), rsp)
        `CHK("dc_size", DC_CAP, rsp.rd_data[21:18])
        `CHK("dc_ways", 3'h2, rsp.rd_data[17:15])
        `CHK("dc_absent", 1'b0, rsp.rd_data[14])
        `CHK("dc_line", 2'h2, rsp.rd_data[13:12])
        @(negedge ref_clk);
    endtask
    task automatic t_misc;
        xact("wr_reg0", 1'b0, 4'h0, 3'h0, 4'hF, 1'b1, 1'b1, rs(2'h0, 32'h0));
        xact("rd_reg3", 1'b1, 4'h3, 3'h0, 4'hF, 1'b1, 1'b1, rs(2'h1, 32'h0));
        xact("usr_rd", 1'b1, 4'h0, 3'h0, 4'hF, 1'b0, 1'b1, rs(2'h2, 32'h0));
        xact("usr_wr", 1'b0, 4'h0, 3'h0, 4'hF, 1'b0, 1'b1, rs(2'h2, 32'h0));
        xact("data_op", 1'b1, 4'h0, 3'h0, 4'hF, 1'b1, 1'b0, rs(2'h2, 32'h0));
        xact("other_cp", 1'b1, 4'h0, 3'h0, 4'hE, 1'b1, 1'b1, 35'h0);
    endtask
    initial begin
        repeat (600) @(posedge ref_clk);
        err_total++;
        tally_and_finish();
    end
    initial begin
        err_total = 0;
        n_tests = 0;
        t_reset(1'b1);
        t_reset(1'b0);
        t_reg0();
        t_cache();
        t_misc();
        tally_and_finish();
    end
endmodule
`default_nettype wire
